/* src/acsl_unit.sv */
// Notes on behaviour
// - real value always fills two consecutive words
// - store word writes acc low half, keeps acc
// - store double writes acc to two words
// - word and double stores report solve failure
// - bit field store copies 1-32 low bits
// - pop moves stack top into acc, shifts up
// - pop sets zero flag from new acc
// - indexed store writes stack low half, base+acc
// - indexed store clears acc upper half
// - back to back loads push first value
// - low byte store copies acc bits 7:0
// - high byte store copies acc bits 15:8
// - 16-bit conjunction ands acc low with word
// - 16-bit conjunction sets or clears zero flag
// - double conjunction ands acc with pair or constant
// - double conjunction sets zero and negative flags
// - flag holds until next updating operation
`timescale 1ns/100ps
`default_nettype none
module acsl_unit
#(
  parameter int DEPTH = acsl_pkg::STK_DEPTH
)
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  input  wire logic                        op_valid,
  input  wire acsl_pkg::acsl_op_e          op,
  input  wire logic [acsl_pkg::ADDR_W-1:0] op_addr,
  input  wire logic [acsl_pkg::CNT_W-1:0]  op_cnt,
  input  wire logic [acsl_pkg::ACC_W-1:0]  op_const,
  input  wire logic                        op_use_const,
  input  wire logic [acsl_pkg::ACC_W-1:0]  ld_data,
  input  wire logic                        solve_err,
  output logic                             op_ready,
  output logic                             op_done,
  output logic      [acsl_pkg::ACC_W-1:0]  acc,
  output logic                             zero_result_flag,
  output logic                             negative_result_flag,
  output logic                             solve_fail_flag,
  output logic                             wm_req,
  output logic                             wm_we,
  output logic      [1:0]                  wm_be,
  output logic      [acsl_pkg::ADDR_W-1:0] wm_addr,
  output logic      [acsl_pkg::WORD_W-1:0] wm_wdata,
  input  wire logic [acsl_pkg::WORD_W-1:0] wm_rdata,
  input  wire logic                        wm_rvalid,
  output logic                             bm_we,
  output logic      [acsl_pkg::ADDR_W-1:0] bm_addr,
  output logic                             bm_wdata
);
  import acsl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    acsl_state_e       st;
    acsl_op_e          op;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0]  cnt_m1;
    logic [CNT_W-1:0]  idx;
    logic [WORD_W-1:0] lo;
    logic              last_load;
    logic [ACC_W-1:0]  acc;
    logic              zf;
    logic              nf;
    logic              sf;
    logic              ready;
    logic              done;
    logic              wm_req;
    logic              wm_we;
    logic [1:0]        wm_be;
    logic [ADDR_W-1:0] wm_addr;
    logic [WORD_W-1:0] wm_wdata;
    logic              bm_we;
    logic [ADDR_W-1:0] bm_addr;
    logic              bm_wdata;
  } acsl_unit_s;

  acsl_unit_s         r;
  acsl_unit_s         n;
  logic               push;
  logic               pop;
  logic [ACC_W-1:0]   stk_top;
  logic [ACC_W-1:0]   res;
  logic               take;
  logic [WORD_W-1:0]  acc_lo;
  logic [WORD_W-1:0]  top_lo;
  logic [ACC_W-1:0]   conj_k;

  assign take   = ce && op_valid && (r.st == ST_IDLE);
  assign acc_lo = r.acc[WORD_W-1:0];
  assign top_lo = stk_top[WORD_W-1:0];
  assign conj_k = r.acc & op_const;

  // ----------------------------------------------------------------
  // accumulator stack
  // ----------------------------------------------------------------
  acsl_stack #(
    .DEPTH     (DEPTH)
  ) u_stack (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .push      (push),
    .pop       (pop),
    .push_data (r.acc),
    .top       (stk_top)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n        = r;
    n.done   = 1'b0;
    n.wm_req = 1'b0;
    n.bm_we  = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    res      = r.acc;
    unique case (r.st)
      ST_IDLE:
      begin
        if (op_valid)
        begin
          n.op        = op;
          n.addr      = op_addr;
          n.idx       = '0;
          n.last_load = (op == OP_LOAD);
          n.ready     = 1'b0;
          // counts outside 1..32 are clamped to the nearest end
          if (op_cnt == '0)
            n.cnt_m1 = '0;
          else if (op_cnt > BITS_MAX)
            n.cnt_m1 = BITS_MAX - 6'h1;
          else
            n.cnt_m1 = op_cnt - 6'h1;
          unique case (op)
            OP_LOAD:
            begin
              push    = r.last_load;
              n.acc   = ld_data;
              n.zf    = (ld_data == '0);
              n.nf    = ld_data[ACC_W-1];
              n.done  = 1'b1;
              n.ready = 1'b1;
            end
            OP_POP:
            begin
              pop     = 1'b1;
              n.acc   = stk_top;
              n.zf    = (stk_top == '0);
              n.done  = 1'b1;
              n.ready = 1'b1;
            end
            OP_ST_WORD, OP_ST_LOW, OP_ST_HIGH:
            begin
              n.wm_req   = 1'b1;
              n.wm_we    = 1'b1;
              n.wm_addr  = op_addr;
              n.wm_wdata = acc_lo;
              // byte enables keep the other byte intact
              if (op == OP_ST_LOW)
                n.wm_be = BE_LOW;
              else if (op == OP_ST_HIGH)
                n.wm_be = BE_HIGH;
              else
              begin
                n.wm_be = BE_WORD;
                n.sf    = solve_err;
              end
              n.st = ST_WR_HI;
            end
            OP_ST_DBL:
            begin
              // a real value is stored this same way, low word first
              n.wm_req   = 1'b1;
              n.wm_we    = 1'b1;
              n.wm_be    = BE_WORD;
              n.wm_addr  = op_addr;
              n.wm_wdata = acc_lo;
              n.sf       = solve_err;
              n.st       = ST_WR_LO;
            end
            OP_ST_IDX:
            begin
              n.wm_req   = 1'b1;
              n.wm_we    = 1'b1;
              n.wm_be    = BE_WORD;
              n.wm_addr  = op_addr + acc_lo;
              n.wm_wdata = top_lo;
              n.acc      = {16'h0, acc_lo};
              n.st       = ST_WR_HI;
            end
            OP_ST_BITS:
              n.st = ST_BITS;
            OP_CONJ:
            begin
              n.wm_req  = 1'b1;
              n.wm_we   = 1'b0;
              n.wm_addr = op_addr;
              n.st      = ST_RD_LO;
            end
            OP_CONJ_DBL:
            begin
              if (op_use_const)
              begin
                n.acc   = conj_k;
                n.zf    = (conj_k == '0);
                n.nf    = conj_k[ACC_W-1];
                n.done  = 1'b1;
                n.ready = 1'b1;
              end
              else
              begin
                n.wm_req  = 1'b1;
                n.wm_we   = 1'b0;
                n.wm_addr = op_addr;
                n.st      = ST_RD_LO;
              end
            end
            default:
            begin
              n.done  = 1'b1;
              n.ready = 1'b1;
            end
          endcase
        end
      end
      ST_WR_LO:
      begin
        n.wm_req   = 1'b1;
        n.wm_addr  = r.wm_addr + HI_OFFSET;
        n.wm_wdata = r.acc[ACC_W-1:WORD_W];
        n.st       = ST_WR_HI;
      end
      ST_WR_HI:
      begin
        n.done  = 1'b1;
        n.ready = 1'b1;
        n.st    = ST_IDLE;
      end
      ST_BITS:
      begin
        n.bm_we    = 1'b1;
        n.bm_addr  = r.addr + {10'h0, r.idx};
        n.bm_wdata = r.acc[r.idx[4:0]];
        n.idx      = r.idx + 6'h1;
        if (r.idx == r.cnt_m1)
          n.st = ST_WR_HI;
      end
      ST_RD_LO:
      begin
        if (wm_rvalid)
        begin
          if (r.op == OP_CONJ)
          begin
            res     = {16'h0, acc_lo & wm_rdata};
            n.acc   = res;
            n.zf    = (res == '0);
            n.done  = 1'b1;
            n.ready = 1'b1;
            n.st    = ST_IDLE;
          end
          else
          begin
            n.lo      = wm_rdata;
            n.wm_req  = 1'b1;
            n.wm_addr = r.addr + HI_OFFSET;
            n.st      = ST_RD_HI;
          end
        end
      end
      ST_RD_HI:
      begin
        if (wm_rvalid)
        begin
          res     = r.acc & {wm_rdata, r.lo};
          n.acc   = res;
          n.zf    = (res == '0);
          n.nf    = res[ACC_W-1];
          n.done  = 1'b1;
          n.ready = 1'b1;
          n.st    = ST_IDLE;
        end
      end
      default:
      begin
        n.ready = 1'b1;
        n.st    = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r       <= '0;
      r.ready <= 1'b1;
    end
    else if (ce)
      r <= n;
  end

  assign op_ready             = r.ready;
  assign op_done              = r.done;
  assign acc                  = r.acc;
  assign zero_result_flag     = r.zf;
  assign negative_result_flag = r.nf;
  assign solve_fail_flag      = r.sf;
  assign wm_req               = r.wm_req;
  assign wm_we                = r.wm_we;
  assign wm_be                = r.wm_be;
  assign wm_addr              = r.wm_addr;
  assign wm_wdata             = r.wm_wdata;
  assign bm_we                = r.bm_we;
  assign bm_addr              = r.bm_addr;
  assign bm_wdata             = r.bm_wdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_st_word;
    take && op == OP_ST_WORD |=> wm_req && wm_we && wm_be == BE_WORD
      && wm_wdata == acc[15:0] && $stable(acc);
  endproperty
  a_st_word: assert property (p_st_word)
    else $error("store word data or acc wrong");

  property p_st_dbl;
    take && op == OP_ST_DBL ##1 ce |=> wm_req
      && wm_addr == $past(wm_addr) + HI_OFFSET
      && wm_wdata == acc[31:16];
  endproperty
  a_st_dbl: assert property (p_st_dbl)
    else $error("store double high word wrong");

  property p_solve;
    take && (op == OP_ST_WORD || op == OP_ST_DBL)
      |=> solve_fail_flag == $past(solve_err);
  endproperty
  a_solve: assert property (p_solve)
    else $error("solve fail flag not updated");

  property p_bits;
    ce && r.st == ST_BITS |=> bm_we
      && bm_addr == $past(r.addr) + {10'h0, $past(r.idx)};
  endproperty
  a_bits: assert property (p_bits)
    else $error("bit field address wrong");

  property p_pop;
    take && op == OP_POP |=> acc == $past(stk_top)
      && zero_result_flag == (acc == '0);
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop result or zero flag wrong");

  property p_idx;
    take && op == OP_ST_IDX |=> wm_addr == $past(op_addr) + $past(acc_lo)
      && wm_wdata == $past(top_lo) && acc[31:16] == 16'h0;
  endproperty
  a_idx: assert property (p_idx)
    else $error("indexed store wrong");

  property p_push;
    take && op == OP_LOAD && r.last_load |=> stk_top == $past(acc);
  endproperty
  a_push: assert property (p_push)
    else $error("second load did not push");

  property p_bytes;
    take && (op == OP_ST_LOW || op == OP_ST_HIGH) |=> wm_req
      && wm_be == ($past(op) == OP_ST_LOW ? BE_LOW : BE_HIGH)
      && wm_wdata == acc[15:0];
  endproperty
  a_bytes: assert property (p_bytes)
    else $error("byte store enables wrong");

  property p_conj;
    ce && r.st == ST_RD_LO && r.op == OP_CONJ && wm_rvalid
      |=> acc == {16'h0, $past(acc_lo) & $past(wm_rdata)}
      && zero_result_flag == (acc == '0) && op_done;
  endproperty
  a_conj: assert property (p_conj)
    else $error("16-bit conjunction wrong");

  property p_conj_k;
    take && op == OP_CONJ_DBL && op_use_const |=> acc == $past(conj_k)
      && negative_result_flag == acc[31]
      && zero_result_flag == (acc == '0);
  endproperty
  a_conj_k: assert property (p_conj_k)
    else $error("double conjunction wrong");

endmodule
`default_nettype wire

/* src/acsl_pkg.sv */
package acsl_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int ACC_W     = 32;
  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 16;
  localparam int CNT_W     = 6;
  localparam int STK_DEPTH = 8;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [1:0]        BE_LOW    = 2'h1;
  localparam logic [1:0]        BE_HIGH   = 2'h2;
  localparam logic [1:0]        BE_WORD   = 2'h3;
  localparam logic [CNT_W-1:0]  BITS_MAX  = 6'h20;
  localparam logic [ACC_W-1:0]  ACC_RST   = 32'h0;
  localparam logic [ADDR_W-1:0] HI_OFFSET = 16'h1;

  // ----------------------------------------------------------------
  // operations issued by the sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_LOAD      = 4'h1,
    OP_ST_WORD   = 4'h2,
    OP_ST_DBL    = 4'h3,
    OP_ST_BITS   = 4'h4,
    OP_POP       = 4'h5,
    OP_ST_IDX    = 4'h6,
    OP_ST_LOW    = 4'h7,
    OP_ST_HIGH   = 4'h8,
    OP_CONJ      = 4'h9,
    OP_CONJ_DBL  = 4'ha
  } acsl_op_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WR_LO = 3'h1,
    ST_WR_HI = 3'h3,
    ST_BITS  = 3'h2,
    ST_RD_LO = 3'h6,
    ST_RD_HI = 3'h7
  } acsl_state_e;

endpackage

/* src/acsl_stack.sv */
`timescale 1ns/100ps
`default_nettype none
module acsl_stack
#(
  parameter int DEPTH = acsl_pkg::STK_DEPTH
)
(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic                       push,
  input  wire logic                       pop,
  input  wire logic [acsl_pkg::ACC_W-1:0] push_data,
  output logic      [acsl_pkg::ACC_W-1:0] top
);
  import acsl_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][ACC_W-1:0] e;
  } acsl_stk_s;

  acsl_stk_s                   r;
  acsl_stk_s                   nxt;
  logic [DEPTH-1:0][ACC_W-1:0] e_nxt;

  // ----------------------------------------------------------------
  // per level shift; push moves down, pop moves every level up
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_lvl
      logic [ACC_W-1:0] below;
      logic [ACC_W-1:0] above;
      if (g == 0)
      begin : g_first
        assign above = push_data;
      end
      else
      begin : g_mid
        assign above = r.e[g-1];
      end
      if (g == DEPTH-1)
      begin : g_last
        assign below = ACC_RST;
      end
      else
      begin : g_rest
        assign below = r.e[g+1];
      end
      assign e_nxt[g] = push ? above : (pop ? below : r.e[g]);
    end
  endgenerate

  always_comb
  begin
    nxt   = r;
    nxt.e = e_nxt;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else if (ce)
      r <= nxt;
  end

  assign top = r.e[0];

endmodule
`default_nettype wire

/* dv/acsl_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module acsl_mem_model
  import acsl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [2:0]        lat,
  input  wire logic              wm_req,
  input  wire logic              wm_we,
  input  wire logic [1:0]        wm_be,
  input  wire logic [ADDR_W-1:0] wm_addr,
  input  wire logic [WORD_W-1:0] wm_wdata,
  output logic      [WORD_W-1:0] wm_rdata,
  output logic                   wm_rvalid,
  input  wire logic              bm_we,
  input  wire logic [ADDR_W-1:0] bm_addr,
  input  wire logic              bm_wdata
);
  logic [WORD_W-1:0] wmem [64];
  logic              bmem [64];
  logic [2:0]        wait_r;
  logic              busy_r;
  logic [5:0]        raddr_r;

  initial
  begin
    wm_rdata  = 16'h0;
    wm_rvalid = 1'b0;
    busy_r    = 1'b0;
    wait_r    = 3'h0;
    raddr_r   = 6'h0;
  end

  // ----------------------------------------------------------------
  // word and bit memory, read latency set by lat
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    wm_rvalid <= 1'b0;
    // data line not held between answers: keep it moving
    wm_rdata  <= ~wm_rdata;
    if (wm_req && wm_we)
    begin
      // byte lanes only, the other byte keeps its value
      if (wm_be[0]) wmem[wm_addr[5:0]][7:0] <= wm_wdata[7:0];
      if (wm_be[1]) wmem[wm_addr[5:0]][15:8] <= wm_wdata[15:8];
    end
    if (wm_req && !wm_we)
    begin
      busy_r  <= 1'b1;
      wait_r  <= lat;
      raddr_r <= wm_addr[5:0];
    end
    else if (busy_r)
    begin
      if (wait_r <= 3'h1)
      begin
        wm_rvalid <= 1'b1;
        wm_rdata  <= wmem[raddr_r];
        busy_r    <= 1'b0;
      end
      else
        wait_r <= wait_r - 3'h1;
    end
    if (bm_we) bmem[bm_addr[5:0]] <= bm_wdata;
  end
endmodule
`default_nettype wire

/* dv/acsl_unit_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module acsl_unit_tb_top;
  import acsl_pkg::*;
  logic              clk, rst_n, ce, op_valid, op_use_const, solve_err;
  acsl_op_e          op;
  logic [ADDR_W-1:0] op_addr;
  logic [CNT_W-1:0]  op_cnt;
  logic [ACC_W-1:0]  op_const, ld_data, acc;
  logic              op_ready, op_done, zf, nf, sff;
  logic              wm_req, wm_we, wm_rvalid, bm_we, bm_wdata;
  logic [1:0]        wm_be;
  logic [ADDR_W-1:0] wm_addr, bm_addr;
  logic [WORD_W-1:0] wm_wdata, wm_rdata;
  logic [2:0]        lat;
  int                err_total, cmp_count;

  acsl_unit #(.DEPTH(8)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
    .op_valid(op_valid), .op(op), .op_addr(op_addr), .op_cnt(op_cnt),
    .op_const(op_const), .op_use_const(op_use_const),
    .ld_data(ld_data), .solve_err(solve_err), .op_ready(op_ready),
    .op_done(op_done), .acc(acc), .zero_result_flag(zf),
    .negative_result_flag(nf), .solve_fail_flag(sff), .wm_req(wm_req),
    .wm_we(wm_we), .wm_be(wm_be), .wm_addr(wm_addr),
    .wm_wdata(wm_wdata), .wm_rdata(wm_rdata), .wm_rvalid(wm_rvalid),
    .bm_we(bm_we), .bm_addr(bm_addr), .bm_wdata(bm_wdata));

  acsl_mem_model mem_u (.clk(clk), .lat(lat), .wm_req(wm_req),
    .wm_we(wm_we), .wm_be(wm_be), .wm_addr(wm_addr),
    .wm_wdata(wm_wdata), .wm_rdata(wm_rdata), .wm_rvalid(wm_rvalid),
    .bm_we(bm_we), .bm_addr(bm_addr), .bm_wdata(bm_wdata));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t %s: %h vs %h", $time, msg, seen, exp);
    end
  endtask

  function automatic logic [31:0] w(input int a);
    return {16'h0, mem_u.wmem[a]};
  endfunction

  // d feeds load data, constant and bit count alike
  task automatic do_op(input acsl_op_e o, input logic [15:0] a,
                       input logic [31:0] d);
    int n;
    @(negedge clk);
    op       = o;
    op_addr  = a;
    op_cnt   = d[5:0];
    op_const = d;
    ld_data  = d;
    op_valid = 1'b1;
    n = 0;
    @(negedge clk);
    op_valid = 1'b0;
    while (op_done !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    // the bound may run out on the very cycle that done shows up
    if (op_done !== 1'b1)
    begin
      err_total++;
      close_out();
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_stack();
    do_op(OP_LOAD, 16'h0, 32'h1111_0001);
    do_op(OP_LOAD, 16'h0, 32'h8000_0002);
    do_op(OP_LOAD, 16'h0, 32'h0000_0003);
    do_op(OP_POP, 16'h0, 32'h0);
    check(acc, 32'h8000_0002, "pop 1");
    check({31'h0, zf}, 32'h0, "pop zf");
    check({31'h0, nf}, 32'h0, "pop nf");
    do_op(OP_POP, 16'h0, 32'h0);
    check(acc, 32'h1111_0001, "pop 2");
    do_op(OP_POP, 16'h0, 32'h0);
    check(acc, 32'h0, "pop 3");
    check({31'h0, zf}, 32'h1, "pop zf 0");
  endtask

  task automatic t_word();
    do_op(OP_LOAD, 16'h0, 32'hdead_1234);
    solve_err = 1'b1;
    do_op(OP_ST_WORD, 16'h4, 32'h0);
    check(w(4), 32'h1234, "st word");
    check(acc, 32'hdead_1234, "acc kept");
    check({31'h0, sff}, 32'h1, "solve flag");
    solve_err = 1'b0;
    do_op(OP_ST_DBL, 16'h8, 32'h0);
    check(w(8), 32'h1234, "dbl lo");
    check(w(9), 32'hdead, "dbl hi");
    check({31'h0, sff}, 32'h0, "solve clr");
  endtask

  task automatic t_bits();
    logic [31:0] v;
    logic [5:0]  cl [5];
    int          n;
    logic        pre;
    v = 32'ha5c3_96e1;
    cl = '{6'h0, 6'h1, 6'h7, 6'h20, 6'h3f};
    do_op(OP_LOAD, 16'h0, v);
    foreach (cl[i])
    begin
      n = (cl[i] == 6'h0) ? 1 : ((cl[i] > 6'h20) ? 32 : int'(cl[i]));
      for (int b = 0; b < 40; b++)
        mem_u.bmem[b] = (b >= 4 && b < 36) ? ~v[b-4] : 1'b1;
      do_op(OP_ST_BITS, 16'h4, {26'h0, cl[i]});
      for (int b = 0; b < 40; b++)
      begin
        pre = (b >= 4 && b < 36) ? ~v[b-4] : 1'b1;
        check({31'h0, mem_u.bmem[b]},
              {31'h0, (b >= 4 && b < 4 + n) ? v[b-4] : pre},
              "bit field");
      end
    end
  endtask

  task automatic t_index();
    mem_u.wmem[6'h15] = 16'h0;
    do_op(OP_LOAD, 16'h0, 32'h0000_abcd);
    do_op(OP_LOAD, 16'h0, 32'h1234_0005);
    do_op(OP_ST_IDX, 16'h10, 32'h0);
    check(w(32'h15), 32'habcd, "indexed");
    check(acc, 32'h0000_0005, "idx acc");
  endtask

  task automatic t_bytes();
    mem_u.wmem[6'h20] = 16'h5a5a;
    mem_u.wmem[6'h21] = 16'h5a5a;
    do_op(OP_LOAD, 16'h0, 32'h0000_c3a7);
    do_op(OP_ST_LOW, 16'h20, 32'h0);
    do_op(OP_ST_HIGH, 16'h21, 32'h0);
    check(w(32'h20), 32'h5aa7, "low byte");
    check(w(32'h21), 32'hc35a, "high byte");
  endtask

  task automatic t_conj();
    mem_u.wmem[6'h30] = 16'h0ff0;
    mem_u.wmem[6'h32] = 16'h0000;
    mem_u.wmem[6'h33] = 16'h8000;
    do_op(OP_LOAD, 16'h0, 32'hffff_f00f);
    lat = 3'h3;
    do_op(OP_CONJ, 16'h30, 32'h0);
    check(acc, 32'h0, "and 16");
    check({31'h0, zf}, 32'h1, "and zf");
    check({31'h0, nf}, 32'h1, "and nf kept");
    lat = 3'h1;
    do_op(OP_LOAD, 16'h0, 32'h1234_3ff0);
    do_op(OP_CONJ, 16'h30, 32'h0);
    check(acc, 32'h0000_0ff0, "and 16 b");
    check({31'h0, zf}, 32'h0, "and zf b");
    do_op(OP_LOAD, 16'h0, 32'hffff_ffff);
    lat = 3'h2;
    do_op(OP_CONJ_DBL, 16'h32, 32'h0);
    check(acc, 32'h8000_0000, "and 32 mem");
    check({30'h0, zf, nf}, 32'h1, "and 32 flags");
    op_use_const = 1'b1;
    do_op(OP_CONJ_DBL, 16'h0, 32'h0fff_ffff);
    op_use_const = 1'b0;
    check(acc, 32'h0, "and 32 const");
    check({30'h0, zf, nf}, 32'h2, "const flags");
  endtask

  // ce low must freeze everything, then a reset in mid-run clears it all
  task automatic t_hold();
    logic [31:0] a0;
    int          k;
    a0 = acc;
    k  = 0;
    @(negedge clk);
    ce       = 1'b0;
    op       = OP_LOAD;
    ld_data  = 32'h5555_0000;
    op_valid = 1'b1;
    repeat (4)
    begin
      @(negedge clk);
      if (op_done !== 1'b0 || acc !== a0 || op_ready !== 1'b1)
        k++;
    end
    op_valid = 1'b0;
    ce       = 1'b1;
    check(k, 32'h0, "ce freeze");
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    check(acc, 32'h0, "acc reset 2");
    check({31'h0, op_ready}, 32'h1, "ready reset 2");
    @(negedge clk);
    check({29'h0, zf, nf, sff}, 32'h0, "flags reset 2");
    do_op(OP_POP, 16'h0, 32'h0);
    check(acc, 32'h0, "stack cleared");
    check({31'h0, zf}, 32'h1, "stack cleared zf");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    op_valid = 1'b0;
    op = OP_NOP;
    op_addr = 16'h0;
    op_cnt = 6'h0;
    op_const = 32'h0;
    op_use_const = 1'b0;
    ld_data = 32'h0;
    solve_err = 1'b0;
    lat = 3'h1;
    err_total = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    check(acc, 32'h0, "acc reset");
    check({31'h0, op_ready}, 32'h1, "ready reset");
    t_stack();
    t_word();
    t_bits();
    t_index();
    t_bytes();
    t_conj();
    t_hold();
    close_out();
  end
endmodule
`default_nettype wire
